// >>> verilog/flash_cmd_pkg.sv
package flash_cmd_pkg;

  // ----------------------------------------------------------------
  // command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_WRITE_ARM  = 8'h06;  // sets the write latch
  localparam logic [7:0] OPC_STATUS     = 8'h05;  // status byte read
  localparam logic [7:0] OPC_PAGE       = 8'h02;  // single line page write
  localparam logic [7:0] OPC_QPAGE      = 8'h32;  // four line page write
  localparam logic [7:0] OPC_SECTOR     = 8'h20;  // sector wipe
  localparam logic [7:0] OPC_BLK32      = 8'h52;  // small block wipe
  localparam logic [7:0] OPC_BLK64      = 8'hd8;  // large block wipe
  localparam logic [7:0] OPC_CHIP_A     = 8'h60;  // full wipe, first code
  localparam logic [7:0] OPC_CHIP_B     = 8'hc7;  // full wipe, second code
  localparam logic [7:0] OPC_MAKER_PART = 8'h90;  // maker and part query
  localparam logic [7:0] OPC_IDENT      = 8'h9f;  // three byte ident query

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_EDGES = 6'd8;    // edges in an opcode
  localparam logic [5:0] HDR_EDGES = 6'd32;   // opcode plus three address bytes
  localparam int         PAGE_BYTES = 256;    // bytes in one page
  localparam logic [2:0] QUAD_STEP = 3'd4;    // bits per edge on four lines
  localparam logic [2:0] SER_STEP  = 3'd1;    // bits per edge on one line

  // ----------------------------------------------------------------
  // status byte layout
  // ----------------------------------------------------------------
  localparam int ST_BUSY_BIT  = 0;  // busy flag
  localparam int ST_LATCH_BIT = 1;  // write latch flag
  localparam int ST_PROT_LSB  = 2;  // protect field, five bits upward

  // ----------------------------------------------------------------
  // identification values (arbitrary, neutral)
  // ----------------------------------------------------------------
  localparam logic [7:0] MAKER_CODE = 8'h5a;  // arbitrary value
  localparam logic [7:0] PART_CODE  = 8'h13;  // arbitrary value
  localparam logic [7:0] MEM_TYPE   = 8'h60;  // arbitrary value
  localparam logic [7:0] MEM_CAP    = 8'h14;  // arbitrary value

  // ----------------------------------------------------------------
  // self-timed cycle lengths
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 25;    // core clock rate
  localparam int PAGE_TIME_US    = 600;   // page write time
  localparam int SECTOR_TIME_MS  = 60;    // sector wipe time
  localparam int SMALL_BLK_MS    = 200;   // small_block_wipe_time
  localparam int LARGE_BLK_MS    = 400;   // large_block_wipe_time
  localparam int FULL_WIPE_MS    = 3000;  // full_wipe_time
  localparam int PAGE_CYCLES     = PAGE_TIME_US * CLK_MHZ;
  localparam int SECTOR_CYCLES   = SECTOR_TIME_MS * 1000 * CLK_MHZ;
  localparam int SMALL_BLK_CYCLES = SMALL_BLK_MS * 1000 * CLK_MHZ;
  localparam int LARGE_BLK_CYCLES = LARGE_BLK_MS * 1000 * CLK_MHZ;
  localparam int FULL_WIPE_CYCLES = FULL_WIPE_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W         = 27;    // holds the longest count

  // ----------------------------------------------------------------
  // protection geometry
  // ----------------------------------------------------------------
  localparam logic [4:0] SECT_LOG  = 5'd12;  // 4 KB unit
  localparam logic [4:0] BLOCK_LOG = 5'd16;  // 64 KB unit
  localparam logic [4:0] ARRAY_LOG = 5'd20;  // 1 MB array

  // kind of self-timed operation handed to the array
  typedef enum logic [2:0] {
    OP_NONE, OP_PAGE, OP_QPAGE, OP_SECTOR, OP_BLK32, OP_BLK64, OP_CHIP
  } op_kind_t;

  // busy sequencer states
  typedef enum logic {ST_IDLE, ST_RUN} seq_state_t;

  // true when addr falls in the region that the protect field guards
  function automatic logic prot_hit(input logic [23:0] addr,
                                    input logic [4:0]  bp,
                                    input logic        inv);
    logic [4:0]  span_log;
    logic [19:0] hi;
    logic        hit;
    span_log = (bp[4] ? SECT_LOG : BLOCK_LOG) + {2'b00, bp[2:0]} - 5'd1;
    hi       = addr[19:0] >> span_log;
    if (bp[2:0] == 3'h0)
      hit = 1'b0;
    else if (span_log >= ARRAY_LOG)
      hit = 1'b1;
    else if (bp[3])
      hit = (hi == 20'h0);
    else
      hit = (hi == (20'hfffff >> span_log));
    return hit ^ inv;
  endfunction : prot_hit

endpackage : flash_cmd_pkg

// >>> verilog/flash_cmd_core.sv
`timescale 1ns/10ps
module flash_cmd_core
  import flash_cmd_pkg::*;
#(
  parameter int PGM_CYCLES   = PAGE_CYCLES,       // page write length
  parameter int SECT_CYCLES  = SECTOR_CYCLES,     // sector wipe length
  parameter int BLK32_CYCLES = SMALL_BLK_CYCLES,  // small block length
  parameter int BLK64_CYCLES = LARGE_BLK_CYCLES,  // large block length
  parameter int CHIP_CYCLES  = FULL_WIPE_CYCLES   // full wipe length
)(
  input  wire logic        clk,              // core clock
  input  wire logic        rst,              // synchronous reset
  input  wire logic        sclk,             // serial clock from host
  input  wire logic        cs_n,             // chip select, low active
  input  wire logic [3:0]  dq_in,            // data lines seen from pins
  output logic      [3:0]  dq_out,           // data lines driven
  output logic      [3:0]  dq_oe,            // drive enables
  input  wire logic        protect_bit4,     // protect field
  input  wire logic        protect_bit3,
  input  wire logic        protect_bit2,
  input  wire logic        protect_bit1,
  input  wire logic        protect_bit0,
  input  wire logic        protect_invert,   // flips protected area
  input  wire logic        quad_io_enable,   // allows four-line write
  output logic             busy_flag,        // timed cycle running
  output logic             write_latch_flag, // writes armed
  output logic             op_start,         // one-cycle start to array
  output op_kind_t         op_kind,          // operation kind
  output logic      [23:0] op_addr,          // target address
  output logic             op_done,          // one-cycle end of cycle
  input  wire logic [7:0]  wbuf_idx,         // page buffer read index
  output logic      [7:0]  wbuf_data,        // buffered byte
  output logic             wbuf_keep         // byte was written
);

  // ----------------------------------------------------------------
  // serial domain: frame capture
  // ----------------------------------------------------------------
  logic        start_pend_reg;     // next edge is a frame's first
  logic [5:0]  cnt_reg;            // header edges, saturates
  logic [7:0]  op_reg;             // opcode
  logic [23:0] addr_reg;           // address
  logic [2:0]  sub_reg;            // bit position in data byte
  logic [1:0]  rep_reg;            // reply byte index
  logic        got_reg;            // a whole data byte arrived
  logic [7:0]  asm_reg;            // data byte being assembled
  logic [7:0]  wptr_reg;           // offset inside the page
  logic [7:0]  mem [PAGE_BYTES];   // page buffer
  logic [PAGE_BYTES-1:0] keep_reg; // which buffer bytes are written
  logic [6:0]  st_s1_reg;          // status into serial domain, stage 1
  logic [6:0]  st_s2_reg;          // status into serial domain, stage 2
  logic        so_reg;             // serial out bit
  logic        so_oe_reg;          // serial out enable

  logic        short_op_w;         // opcode has no address
  logic        quad_w;             // four-line data phase
  logic        data_w;             // header complete
  logic [2:0]  step_w;             // bits per edge
  logic [2:0]  sub_next;           // next bit position
  logic [7:0]  asm_next;           // byte after this edge
  logic        byte_end_w;         // this edge completes a byte
  logic        pgm_op_w;           // page write opcode
  logic        reply_w;            // device talks in this frame
  logic [7:0]  tx_byte_w;          // byte being sent
  logic        busy_s_w;           // busy seen in serial domain

  assign busy_s_w   = st_s2_reg[ST_BUSY_BIT];
  assign short_op_w = (op_reg == OPC_WRITE_ARM) || (op_reg == OPC_STATUS) ||
                      (op_reg == OPC_IDENT) || (op_reg == OPC_CHIP_A) ||
                      (op_reg == OPC_CHIP_B);
  assign data_w     = cnt_reg >= (short_op_w ? OPC_EDGES : HDR_EDGES);
  assign quad_w     = (op_reg == OPC_QPAGE);
  assign pgm_op_w   = (op_reg == OPC_PAGE) || quad_w;
  assign step_w     = quad_w ? QUAD_STEP : SER_STEP;
  assign sub_next   = sub_reg + step_w;
  assign byte_end_w = (sub_next == 3'h0);
  assign asm_next   = quad_w ? {asm_reg[3:0], dq_in} : {asm_reg[6:0], dq_in[0]};

  // frame start marker, set while select is high
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      start_pend_reg <= 1'b1;
    else
      start_pend_reg <= 1'b0;
  end

  // rising-edge capture
  // header and data bit capture
  always_ff @(posedge sclk)
  begin
    if (start_pend_reg)
    begin
      // first edge of a frame restarts the counters, reply index and opcode
      cnt_reg <= 6'd1;
      op_reg  <= {7'h00, dq_in[0]};
      sub_reg <= 3'h0;
      rep_reg <= 2'h0;
      got_reg <= 1'b0;
    end
    else
    begin
      if (cnt_reg < HDR_EDGES)
        cnt_reg <= cnt_reg + 6'd1;
      if (cnt_reg < OPC_EDGES)
        op_reg <= {op_reg[6:0], dq_in[0]};
      else if (cnt_reg < HDR_EDGES)
        addr_reg <= {addr_reg[22:0], dq_in[0]};
      if (data_w)
      begin
        // data or reply phase
        sub_reg <= sub_next;
        asm_reg <= asm_next;
        if (byte_end_w)
        begin
          rep_reg <= rep_reg + 2'h1;
          got_reg <= 1'b1;
        end
      end
    end
  end

  // wrap inside page
  // page pointer starts at low address byte and wraps at the page end
  always_ff @(posedge sclk)
  begin
    if (!start_pend_reg && cnt_reg == HDR_EDGES - 6'd1)
      wptr_reg <= {addr_reg[6:0], dq_in[0]};
    else if (!start_pend_reg && data_w && byte_end_w && pgm_op_w)
      wptr_reg <= wptr_reg + 8'h01;
  end

  // keep last bytes
  // later bytes overwrite earlier ones, unwritten bytes stay unmarked
  // cleared only by a new page write header, so status polls keep the marks
  always_ff @(posedge sclk)
  begin
    if (!start_pend_reg && cnt_reg == HDR_EDGES - 6'd1 && pgm_op_w && !busy_s_w)
      keep_reg <= '0;
    else if (data_w && byte_end_w && pgm_op_w && !busy_s_w)
      keep_reg[wptr_reg] <= 1'b1;
  end

  // page buffer store; frozen while a cycle consumes it
  always_ff @(posedge sclk)
  begin
    if (!start_pend_reg && data_w && byte_end_w && pgm_op_w && !busy_s_w)
      mem[wptr_reg] <= asm_next;
  end

  // status levels into the serial domain
  always_ff @(posedge sclk)
  begin
    st_s1_reg <= {protect_bit4, protect_bit3, protect_bit2, protect_bit1,
                  protect_bit0, write_latch_flag, busy_flag};
    st_s2_reg <= st_s1_reg;
  end

  // reply byte selection
  always_comb
  begin
    tx_byte_w = 8'h00;
    unique case (op_reg)
      OPC_STATUS: tx_byte_w = {1'b0, st_s2_reg[6:2], st_s2_reg[1:0]};
      OPC_IDENT:
      begin
        if (rep_reg == 2'h0)
          tx_byte_w = MAKER_CODE;
        else if (rep_reg == 2'h1)
          tx_byte_w = MEM_TYPE;
        else
          tx_byte_w = MEM_CAP;
      end
      OPC_MAKER_PART: tx_byte_w = (rep_reg[0] ^ addr_reg[0]) ? PART_CODE : MAKER_CODE;
      default: tx_byte_w = 8'h00;
    endcase
  end

  assign reply_w = data_w && ((op_reg == OPC_STATUS) || (op_reg == OPC_MAKER_PART) ||
                              (op_reg == OPC_IDENT && !busy_s_w));

  // falling-edge shift out
  // serial output, msb first, released when select rises
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      so_reg    <= 1'b0;
      so_oe_reg <= 1'b0;
    end
    else
    begin
      so_reg    <= tx_byte_w[3'd7 - sub_reg];
      so_oe_reg <= reply_w;
    end
  end

  assign dq_out = {2'b00, so_reg, 1'b0};
  assign dq_oe  = {2'b00, so_oe_reg, 1'b0};

  // ----------------------------------------------------------------
  // core domain: frame end and decode
  // ----------------------------------------------------------------
  logic       csn_s1_reg;     // select sync stage 1
  logic       csn_s2_reg;     // select sync stage 2
  logic       csn_d_reg;      // delayed for edge detection
  logic       cs_rise_w;      // frame just ended
  logic [4:0] bp_w;           // protect field
  logic       hdr_exact_w;    // rose right after the address
  logic       pgm_exact_w;    // rose on a data byte boundary
  logic       op_exact_w;     // rose right after the opcode
  logic       prot_w;         // target is guarded
  logic       chip_ok_w;      // full wipe allowed
  op_kind_t   kind_w;         // decoded operation
  logic       start_w;        // launch a timed cycle
  seq_state_t state_reg;      // busy sequencer
  logic [TIMER_W-1:0] timer_reg; // cycles left
  logic [TIMER_W-1:0] load_w;    // length of the cycle to run

  // select level crossing
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      csn_s1_reg <= 1'b1;
      csn_s2_reg <= 1'b1;
      csn_d_reg  <= 1'b1;
    end
    else
    begin
      csn_s1_reg <= cs_n;
      csn_s2_reg <= csn_s1_reg;
      csn_d_reg  <= csn_s2_reg;
    end
  end

  assign cs_rise_w   = csn_s2_reg && !csn_d_reg;
  assign bp_w        = {protect_bit4, protect_bit3, protect_bit2, protect_bit1,
                        protect_bit0};
  assign pgm_exact_w = (cnt_reg == HDR_EDGES) && (sub_reg == 3'h0) && got_reg;
  assign hdr_exact_w = (cnt_reg == HDR_EDGES) && (sub_reg == 3'h0) && !got_reg;
  assign op_exact_w  = (cnt_reg == OPC_EDGES);
  assign prot_w      = prot_hit(addr_reg, bp_w, protect_invert);
  assign chip_ok_w   = (bp_w[2:0] == 3'h0 && !protect_invert) ||
                       (bp_w[2:0] == 3'h7 && protect_invert);

  // decode the finished frame into an operation kind
  always_comb
  begin
    kind_w = OP_NONE;
    unique case (op_reg)
      OPC_PAGE:   if (pgm_exact_w) kind_w = OP_PAGE;
      OPC_QPAGE:  if (pgm_exact_w && quad_io_enable) kind_w = OP_QPAGE;
      OPC_SECTOR: if (hdr_exact_w) kind_w = OP_SECTOR;
      OPC_BLK32:  if (hdr_exact_w) kind_w = OP_BLK32;
      OPC_BLK64:  if (hdr_exact_w) kind_w = OP_BLK64;
      OPC_CHIP_A, OPC_CHIP_B: if (op_exact_w && chip_ok_w) kind_w = OP_CHIP;
      default:    kind_w = OP_NONE;
    endcase
  end

  assign start_w = cs_rise_w && (kind_w != OP_NONE) && write_latch_flag &&
                   (state_reg == ST_IDLE) && (kind_w == OP_CHIP || !prot_w);

  always_comb
  begin
    unique case (kind_w)
      OP_SECTOR: load_w = TIMER_W'(SECT_CYCLES - 1);
      OP_BLK32:  load_w = TIMER_W'(BLK32_CYCLES - 1);
      OP_BLK64:  load_w = TIMER_W'(BLK64_CYCLES - 1);
      OP_CHIP:   load_w = TIMER_W'(CHIP_CYCLES - 1);
      default:   load_w = TIMER_W'(PGM_CYCLES - 1);
    endcase
  end

  // busy sequencer
  // busy from launch to the last counted cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      op_done   <= 1'b0;
    end
    else
    begin
      op_done <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
        begin
          if (start_w)
          begin
            state_reg <= ST_RUN;
            timer_reg <= load_w;
          end
        end
        ST_RUN:
        begin
          if (timer_reg == '0)
          begin
            state_reg <= ST_IDLE;
            op_done   <= 1'b1;
          end
          else
            timer_reg <= timer_reg - 1'b1;
        end
      endcase
    end
  end

  assign busy_flag = (state_reg == ST_RUN);

  // latch consumed at launch
  // write latch: armed by its own command, cleared by a launch
  always_ff @(posedge clk)
  begin
    if (rst)
      write_latch_flag <= 1'b0;
    else if (start_w)
      write_latch_flag <= 1'b0;
    else if (cs_rise_w && op_reg == OPC_WRITE_ARM && op_exact_w && !busy_flag)
      write_latch_flag <= 1'b1;
  end

  // launch information for the array
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      op_start <= 1'b0;
      op_kind  <= OP_NONE;
      op_addr  <= 24'h000000;
    end
    else
    begin
      op_start <= start_w;
      if (start_w)
      begin
        op_kind <= kind_w;
        op_addr <= addr_reg;
      end
    end
  end

  // page buffer read port for the array
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wbuf_data <= 8'h00;
      wbuf_keep <= 1'b0;
    end
    else
    begin
      wbuf_data <= mem[wbuf_idx];
      wbuf_keep <= keep_reg[wbuf_idx];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_BUSY_AFTER_START: assert property (@(posedge clk) disable iff (rst)
    start_w |=> busy_flag && op_start) else $error("busy not raised on launch");
  AST_LATCH_CLEARED: assert property (@(posedge clk) disable iff (rst)
    start_w |=> !write_latch_flag) else $error("latch kept after launch");
  AST_NEEDS_LATCH: assert property (@(posedge clk) disable iff (rst)
    op_start |-> $past(write_latch_flag)) else $error("launch without latch");
  AST_NOT_WHILE_BUSY: assert property (@(posedge clk) disable iff (rst)
    op_start |-> !$past(busy_flag)) else $error("launch during busy");
  AST_AFTER_FRAME: assert property (@(posedge clk) disable iff (rst)
    op_start |-> $past(cs_rise_w)) else $error("launch without frame end");
  AST_CHIP_GATED: assert property (@(posedge clk) disable iff (rst)
    start_w && kind_w == OP_CHIP |-> chip_ok_w) else $error("full wipe protected");
  AST_PAGE_PROT: assert property (@(posedge clk) disable iff (rst)
    start_w && kind_w == OP_PAGE |-> !prot_w) else $error("protected page written");
  AST_QUAD_ENABLE: assert property (@(posedge clk) disable iff (rst)
    start_w && kind_w == OP_QPAGE |-> quad_io_enable) else $error("quad without enable");
  AST_DONE_DROPS: assert property (@(posedge clk) disable iff (rst)
    op_done |-> !busy_flag && $past(busy_flag)) else $error("busy kept after done");
  AST_BUSY_HOLDS: assert property (@(posedge clk) disable iff (rst)
    busy_flag && timer_reg != '0 |=> busy_flag) else $error("busy dropped early");

  COV_PAGE: cover property (@(posedge clk) disable iff (rst) op_start && op_kind == OP_PAGE);
  COV_SECTOR: cover property (@(posedge clk) disable iff (rst) op_start && op_kind == OP_SECTOR);
  COV_CHIP: cover property (@(posedge clk) disable iff (rst) op_start && op_kind == OP_CHIP);
  COV_DONE: cover property (@(posedge clk) disable iff (rst) op_done);

endmodule : flash_cmd_core

// >>> test/spi_host_model.sv
`timescale 1ns/10ps
// ---------------------------------
// host side of the serial link
// ---------------------------------
module spi_host_model (
  output logic       sclk,  // link clock, low between frames
  output logic       cs_n,  // select, low active
  output logic [3:0] dq_in, // data lines toward the device
  input  wire logic  so     // serial reply line
);
  // idle levels at time zero
  initial
  begin
    sclk  = 1'b0;
    cs_n  = 1'b1;
    dq_in = 4'h0;
  end

  task automatic edge_out(input logic [3:0] v);
    dq_in = v;
    #80 sclk = 1'b1;
    #80 sclk = 1'b0;
  endtask : edge_out

  // one frame; qd sends data bytes as nibbles, cut adds stray bits
  task automatic frame(input logic [7:0] q[$], input bit qd, input int cut,
                       input int nrd, output logic [23:0] rd);
    rd = 24'h0;
    #233 cs_n = 1'b0;
    #40;
    foreach (q[i])
      if (qd && i > 3)
      begin
        edge_out(q[i][7:4]);
        edge_out(q[i][3:0]);
      end
      else
        for (int b = 7; b >= 0; b--)
          edge_out({3'b000, q[i][b]});
    repeat (cut) edge_out(4'h0);
    // reply taken just before each rising edge
    repeat (nrd * 8)
    begin
      #80 rd = {rd[22:0], so};
      sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    // released lines flip so stale levels never pass
    dq_in = ~dq_in;
  endtask : frame
endmodule : spi_host_model

// >>> test/test_flash_program_erase_id_cmds.sv
`timescale 1ns/10ps
module test_flash_program_erase_id_cmds
  import flash_cmd_pkg::*;
;
  localparam int PGM = 400; // shortened timed cycles
  localparam int CHIP = 440;
  logic        clk, rst, sclk, cs_n, qe, inv, busy, latch, start, done, keep;
  logic [4:0]  bp;
  logic [3:0]  dq_h, dq_out, dq_oe;
  logic [7:0]  idx, wdata, q[$];
  logic [23:0] op_addr, r;
  op_kind_t    kind;
  int          mismatches, num_checks, cycles;
  logic [7:0]  opc[5] = '{OPC_SECTOR, OPC_BLK32, OPC_BLK64, OPC_CHIP_A, OPC_CHIP_B};
  int          tm[5] = '{410, 420, 430, CHIP, CHIP};
  op_kind_t    kd[5] = '{OP_SECTOR, OP_BLK32, OP_BLK64, OP_CHIP, OP_CHIP};
  wire logic   so = dq_oe[1] ? dq_out[1] : 1'b1; // pulled up when idle

  flash_cmd_core #(.PGM_CYCLES(PGM), .SECT_CYCLES(410), .BLK32_CYCLES(420),
    .BLK64_CYCLES(430), .CHIP_CYCLES(CHIP)) i_flash_cmd_core (.clk(clk), .rst(rst),
    .sclk(sclk), .cs_n(cs_n), .dq_in({dq_h[3:2], dq_oe[1] ? so : dq_h[1], dq_h[0]}),
    .dq_out(dq_out), .dq_oe(dq_oe), .protect_bit4(bp[4]), .protect_bit3(bp[3]),
    .protect_bit2(bp[2]), .protect_bit1(bp[1]), .protect_bit0(bp[0]),
    .protect_invert(inv), .quad_io_enable(qe), .busy_flag(busy),
    .write_latch_flag(latch), .op_start(start), .op_kind(kind), .op_addr(op_addr),
    .op_done(done), .wbuf_idx(idx), .wbuf_data(wdata), .wbuf_keep(keep));
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .dq_in(dq_h), .so(so));

  // core clock
  always #20 clk = ~clk;

  // run limit
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      $display("MISMATCH %0t run limit", $time);
      end_sim;
    end
  end

  task automatic end_sim;
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // status byte: busy, latch, protect field
  task automatic stat(input logic b, input logic l);
    host.frame({OPC_STATUS}, 0, 0, 1, r);
    chk(r, {17'h0, bp, l, b});
  endtask : stat

  task automatic cfg(input logic [4:0] b, input logic i, input logic e);
    @(posedge clk);
    #1 bp = b;
    inv = i;
    qe = e;
  endtask : cfg

  // erase frame from the opcode table
  task automatic mk(input int j);
    q = {opc[j]};
    if (j < 3)
      q = {q, 8'h01, 8'h23, 8'h45};
  endtask : mk

  task automatic wb(input logic [7:0] i, input logic [8:0] e);
    idx = i;
    @(posedge clk);
    #1 chk(24'({keep, wdata & {8{keep}}}), 24'(e));
  endtask : wb

  // arm if asked, send q, expect a launch (cyc > 0) or nothing
  task automatic op(input bit arm, input bit qd, input int cut, input int cyc,
                    input op_kind_t k, input logic [23:0] a);
    int  n;
    time t0;
    n = 0;
    if (arm)
      host.frame({OPC_WRITE_ARM}, 0, 0, 0, r);
    host.frame(q, qd, cut, 0, r);
    while (start !== 1'b1 && n < 12)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(24'(start), 24'(cyc > 0));
    if (cyc > 0)
    begin
      t0 = $time;
      chk(24'(kind), 24'(k));
      if (q.size() > 1)
        chk(op_addr, a);
      chk(24'({busy, latch}), 24'h2);
      host.frame({OPC_WRITE_ARM}, 0, 0, 0, r);
      stat(1'b1, 1'b0);
      host.frame({OPC_IDENT}, 0, 0, 3, r);
      chk(r, 24'hffffff);
      n = 0;
      while (done !== 1'b1 && n < 600)
      begin
        @(posedge clk);
        #1 n++;
      end
      chk(24'(($time - t0) / 40), 24'(cyc));
    end
  endtask : op

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {bp, inv, qe, idx} = 15'h0;
    mismatches = 0;
    num_checks = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    stat(1'b0, 1'b0);
    host.frame({OPC_IDENT}, 0, 0, 3, r);
    chk(r, {MAKER_CODE, MEM_TYPE, MEM_CAP});
    host.frame({OPC_MAKER_PART, 8'h00, 8'h00, 8'h00}, 0, 0, 2, r);
    chk(r, {8'h0, MAKER_CODE, PART_CODE});
    q = {OPC_PAGE, 8'h00, 8'h01, 8'hfe, 8'ha1, 8'hb2, 8'hc3};
    op(1, 0, 0, PGM, OP_PAGE, 24'h0001fe);
    wb(8'hfe, 9'h1a1);
    wb(8'h00, 9'h1c3);
    wb(8'h01, 9'h000);
    mk(0);
    op(0, 0, 0, 0, OP_NONE, 24'h0);
    q = {OPC_PAGE, 8'h00, 8'h00, 8'h00, 8'h77};
    op(1, 0, 3, 0, OP_NONE, 24'h0);
    q = {OPC_QPAGE, 8'h00, 8'h02, 8'h00, 8'h11};
    op(1, 1, 0, 0, OP_NONE, 24'h0);
    cfg(5'h00, 1'b0, 1'b1);
    q = {OPC_QPAGE, 8'h00, 8'h02, 8'h00};
    for (int k = 0; k < 258; k++)
      q.push_back(8'(k / 2));
    op(1, 1, 0, PGM, OP_QPAGE, 24'h000200);
    wb(8'h00, 9'h180);
    wb(8'h02, 9'h101);
    // misframed first, then exact framing, for every erase code
    for (int j = 0; j < 10; j++)
    begin
      mk(j % 5);
      op(1, 0, j < 5, j < 5 ? 0 : tm[j % 5], kd[j % 5], 24'h012345);
    end
    cfg(5'h07, 1'b0, 1'b1);
    for (int j = 0; j < 4; j++)
    begin
      mk(j);
      op(1, 0, 0, 0, OP_NONE, 24'h0);
    end
    q = {OPC_PAGE, 8'h00, 8'h00, 8'h00, 8'h55};
    op(1, 0, 0, 0, OP_NONE, 24'h0);
    cfg(5'h07, 1'b1, 1'b1);
    mk(3);
    op(1, 0, 0, CHIP, OP_CHIP, 24'h0);
    end_sim;
  end
endmodule : test_flash_program_erase_id_cmds
